// ===== das_pkg.sv
// constants shared by the dual access arm sequencer
// Functional notes
// - a seek load starts the targeted arm and retargets read/write
// - automatic mode: after a seek both routing switches move to other arm
// - first seek after reset goes to arm 0
// - second seek after reset goes to arm 1, read/write then uses arm 0
// - control code 4 keeps read/write on the arm just sought
// - next seek without code 4 restores normal alternation
// - inquiry seek and read use last read/write arm, which takes next seek
// - only seeks switch routing; advance and sector jump keep current arm
// - select mode only while select enable is made, else automatic
// - select mode: arm pulse routes all commands to that arm until other pulse
// - arm pulses are ignored while select mode is off
// - select mode: arm 1 used before arm 0 after power-on raises interlock
// - check reset then program start releases the interlock
// - one arm held selected behaves as a single arm system
// - a moving arm obeys only its own address register
package das_pkg;
	localparam int ADDR_W = 20;
	localparam logic [4:0] OFS_SEEK_BUF = 5'h00;
	localparam logic [4:0] OFS_CMD = 5'h04;
	localparam logic [4:0] OFS_STATUS = 5'h08;
	localparam logic [4:0] OFS_ARM0 = 5'h0c;
	localparam logic [4:0] OFS_ARM1 = 5'h10;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_CODE_LSB = 4;
	localparam int CMD_DIGIT_LSB = 8;
	localparam logic [2:0] OP_SEEK = 3'h1;
	localparam logic [2:0] OP_RW = 3'h2;
	localparam logic [2:0] OP_ADVANCE = 3'h3;
	localparam logic [2:0] OP_JUMP = 3'h4;
	localparam logic [2:0] OP_INQUIRY = 3'h5;
	localparam logic [3:0] CODE_HOLD_RW = 4'h4;
	localparam int ST_SEEK_ARM = 0;
	localparam int ST_RW_ARM = 1;
	localparam int ST_SEL_ARM = 2;
	localparam int ST_SEL_MODE = 3;
	localparam int ST_INTERLOCK = 4;
	localparam int ST_ARM0_USED = 5;
	localparam logic [ADDR_W-1:0] ADDR_RST = 20'h0_0000;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage

// ===== das_arm_if.sv
// carrier between sequencer control and per-arm address registers
`timescale 1ns/1ps
`default_nettype none
interface das_arm_if;
	logic ld;
	logic arm;
	logic [das_pkg::ADDR_W-1:0] addr;
	logic adv;
	logic jmp;
	logic [3:0] digit;
	logic [das_pkg::ADDR_W-1:0] a0;
	logic [das_pkg::ADDR_W-1:0] a1;
	modport ctl(output ld, arm, addr, adv, jmp, digit, input a0, a1);
	modport regs(input ld, arm, addr, adv, jmp, digit, output a0, a1);
endinterface
`default_nettype wire

// ===== das_arm_regs.sv
// per-arm address registers with sector advance and sector jump
`timescale 1ns/1ps
`default_nettype none
module das_arm_regs (
	input wire logic clk_i, // 50 MHz clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic ce_i, // clock enable
	das_arm_if.regs bus // control side
);
	typedef struct packed {
		logic [das_pkg::ADDR_W-1:0] a0;
		logic [das_pkg::ADDR_W-1:0] a1;
	} das_regs_t;

	das_regs_t s_r;
	das_regs_t s_nxt;
	logic [das_pkg::ADDR_W-1:0] cur;

	// units digit steps 9 to 0 on the same track
	function automatic logic [das_pkg::ADDR_W-1:0] das_adv(
		input logic [das_pkg::ADDR_W-1:0] a);
		logic [3:0] u;
		u = (a[3:0] == 4'h9) ? 4'h0 : 4'(a[3:0] + 4'h1);
		return {a[das_pkg::ADDR_W-1:4], u};
	endfunction

	always_comb begin
		s_nxt = s_r;
		cur = bus.arm ? s_r.a1 : s_r.a0;
		if (bus.ld) begin
			cur = bus.addr;
		end else if (bus.adv) begin
			cur = das_adv(cur);
		end else if (bus.jmp) begin
			cur = {cur[das_pkg::ADDR_W-1:4], bus.digit};
		end
		if (bus.ld || bus.adv || bus.jmp) begin
			if (bus.arm) begin
				s_nxt.a1 = cur;
			end else begin
				s_nxt.a0 = cur;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_r <= '{a0: das_pkg::ADDR_RST, a1: das_pkg::ADDR_RST};
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign bus.a0 = s_r.a0;
	assign bus.a1 = s_r.a1;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_other_arm_kept: assert property (
		ce_i && bus.ld && bus.arm |=> $stable(bus.a0))
		else $error("load of arm 1 disturbed arm 0 register");
	chk_load_takes_addr: assert property (
		ce_i && bus.ld && !bus.arm |=> bus.a0 == $past(bus.addr))
		else $error("arm 0 register did not take the seek address");
endmodule
`default_nettype wire

// ===== das_seq.sv
// dual access arm sequencer with avalon-mm register slave
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module das_seq (
	input wire logic clk_i, // 50 MHz clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic ce_i, // clock enable, freezes state when low
	input wire logic [4:0] avs_address_i, // byte address
	input wire logic avs_read_i, // read request
	input wire logic avs_write_i, // write request
	input wire logic [31:0] avs_writedata_i, // write data
	output logic [31:0] avs_readdata_o, // read data
	output logic avs_waitrequest_o, // stall
	input wire logic sel_en_i, // select enable connection made
	input wire logic sel0_i, // arm 0 selection impulse
	input wire logic sel1_i, // arm 1 selection impulse
	input wire logic check_reset_i, // check reset impulse
	input wire logic prog_start_i, // program start impulse
	output logic [1:0] seek_go_o, // per-arm seek start pulse
	output logic [1:0] rw_go_o, // per-arm read/write pulse
	output logic rw_arm_o, // arm routed for read/write
	output logic interlock_o, // arm order interlock
	output logic [das_pkg::ADDR_W-1:0] arm0_addr_o, // arm 0 address
	output logic [das_pkg::ADDR_W-1:0] arm1_addr_o // arm 1 address
);
	typedef struct packed {
		logic wreq;
		logic [31:0] rdata;
		logic [das_pkg::ADDR_W-1:0] sbuf;
		logic seek_arm;
		logic rw_arm;
		logic sel_arm;
		logic arm0_used;
		logic interlock;
		logic ckr_pend;
		logic seek_seen;
		logic [1:0] seek_go;
		logic [1:0] rw_go;
		logic [das_pkg::ADDR_W-1:0] a0;
		logic [das_pkg::ADDR_W-1:0] a1;
		logic [4:0] m1;
		logic [4:0] m2;
		logic [4:0] m3;
	} das_state_t;

	das_state_t s_r;
	das_state_t s_nxt;
	das_arm_if arm_bus();

	logic req;
	logic accept;
	logic cmd_wr;
	logic [2:0] op;
	logic [3:0] code;
	logic sel_mode;
	logic sel0_p;
	logic sel1_p;
	logic ckr_p;
	logic pst_p;
	logic tgt;
	logic valid_op;
	logic blocked;
	logic ld;
	logic adv;
	logic jmp;

	function automatic logic [1:0] das_onehot(input logic arm);
		return arm ? 2'b10 : 2'b01;
	endfunction

	das_arm_regs u_regs (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.bus(arm_bus.regs)
	);

	assign arm_bus.ld = ld;
	assign arm_bus.arm = tgt;
	assign arm_bus.addr = s_r.sbuf;
	assign arm_bus.adv = adv;
	assign arm_bus.jmp = jmp;
	assign arm_bus.digit = avs_writedata_i[das_pkg::CMD_DIGIT_LSB +: 4];

	always_comb begin
		s_nxt = s_r;
		// pin synchronisers, edges taken from second stage onward
		s_nxt.m1 = {prog_start_i, check_reset_i, sel1_i, sel0_i, sel_en_i};
		s_nxt.m2 = s_r.m1;
		s_nxt.m3 = s_r.m2;
		sel_mode = s_r.m2[0];
		sel0_p = s_r.m2[1] & ~s_r.m3[1];
		sel1_p = s_r.m2[2] & ~s_r.m3[2];
		ckr_p = s_r.m2[3] & ~s_r.m3[3];
		pst_p = s_r.m2[4] & ~s_r.m3[4];

		req = avs_read_i | avs_write_i;
		accept = req & ~s_r.wreq;
		s_nxt.wreq = ~(req & s_r.wreq);
		cmd_wr = accept & avs_write_i & (avs_address_i == das_pkg::OFS_CMD);
		op = avs_writedata_i[das_pkg::CMD_OP_LSB +: 3];
		code = avs_writedata_i[das_pkg::CMD_CODE_LSB +: 4];

		if (sel_mode) begin
			tgt = s_r.sel_arm;
		end else if (op == das_pkg::OP_SEEK) begin
			tgt = s_r.seek_arm;
		end else begin
			tgt = s_r.rw_arm;
		end
		valid_op = (op == das_pkg::OP_SEEK) || (op == das_pkg::OP_RW) ||
			(op == das_pkg::OP_ADVANCE) || (op == das_pkg::OP_JUMP) ||
			(op == das_pkg::OP_INQUIRY);
		blocked = s_r.interlock | (sel_mode & tgt & ~s_r.arm0_used);
		ld = 1'b0;
		adv = 1'b0;
		jmp = 1'b0;
		s_nxt.seek_go = 2'b00;
		s_nxt.rw_go = 2'b00;

		if (accept & avs_write_i & (avs_address_i == das_pkg::OFS_SEEK_BUF)) begin
			s_nxt.sbuf = avs_writedata_i[das_pkg::ADDR_W-1:0];
		end

		if (cmd_wr && valid_op) begin
			if (blocked) begin
				s_nxt.interlock = 1'b1;
			end else begin
				if (!tgt) begin
					s_nxt.arm0_used = 1'b1;
				end
				case (op)
					das_pkg::OP_SEEK: begin
						ld = 1'b1;
						s_nxt.seek_go = das_onehot(tgt);
						if (sel_mode) begin
							s_nxt.rw_arm = tgt;
						end else begin
							s_nxt.seek_arm = ~tgt;
							if (code == das_pkg::CODE_HOLD_RW) begin
								s_nxt.rw_arm = tgt;
							end else begin
								s_nxt.rw_arm = ~tgt;
							end
						end
					end
					das_pkg::OP_INQUIRY: begin
						ld = 1'b1;
						s_nxt.seek_go = das_onehot(tgt);
						s_nxt.rw_arm = tgt;
						if (!sel_mode) begin
							s_nxt.seek_arm = tgt;
						end
					end
					das_pkg::OP_RW: begin
						s_nxt.rw_go = das_onehot(tgt);
					end
					das_pkg::OP_ADVANCE: begin
						adv = 1'b1;
					end
					das_pkg::OP_JUMP: begin
						jmp = 1'b1;
					end
					default: begin
						ld = 1'b0;
					end
				endcase
			end
		end

		// helper for the first-seek check, set by any arm load
		if (ld) begin
			s_nxt.seek_seen = 1'b1;
		end

		if (sel_mode) begin
			if (sel0_p) begin
				s_nxt.sel_arm = 1'b0;
			end else if (sel1_p) begin
				s_nxt.sel_arm = 1'b1;
			end
		end

		if (s_r.interlock && ckr_p) begin
			s_nxt.ckr_pend = 1'b1;
		end
		if (s_r.ckr_pend && pst_p) begin
			s_nxt.interlock = 1'b0;
			s_nxt.ckr_pend = 1'b0;
			s_nxt.arm0_used = 1'b1;
		end

		s_nxt.a0 = arm_bus.a0;
		s_nxt.a1 = arm_bus.a1;
		if (req && s_r.wreq && avs_read_i) begin
			case (avs_address_i)
				das_pkg::OFS_SEEK_BUF: s_nxt.rdata = 32'(s_r.sbuf);
				das_pkg::OFS_STATUS: begin
					s_nxt.rdata = das_pkg::RDATA_RST;
					s_nxt.rdata[das_pkg::ST_SEEK_ARM] = s_r.seek_arm;
					s_nxt.rdata[das_pkg::ST_RW_ARM] = s_r.rw_arm;
					s_nxt.rdata[das_pkg::ST_SEL_ARM] = s_r.sel_arm;
					s_nxt.rdata[das_pkg::ST_SEL_MODE] = sel_mode;
					s_nxt.rdata[das_pkg::ST_INTERLOCK] = s_r.interlock;
					s_nxt.rdata[das_pkg::ST_ARM0_USED] = s_r.arm0_used;
				end
				das_pkg::OFS_ARM0: s_nxt.rdata = 32'(arm_bus.a0);
				das_pkg::OFS_ARM1: s_nxt.rdata = 32'(arm_bus.a1);
				default: s_nxt.rdata = das_pkg::RDATA_RST;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
			s_r.wreq <= 1'b1;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign avs_readdata_o = s_r.rdata;
	assign avs_waitrequest_o = s_r.wreq;
	assign seek_go_o = s_r.seek_go;
	assign rw_go_o = s_r.rw_go;
	assign rw_arm_o = s_r.rw_arm;
	assign interlock_o = s_r.interlock;
	assign arm0_addr_o = s_r.a0;
	assign arm1_addr_o = s_r.a1;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence seek_cmd;
		ce_i && cmd_wr && op == das_pkg::OP_SEEK && !blocked;
	endsequence
	sequence auto_seek;
		seek_cmd and !sel_mode;
	endsequence

	chk_seek_starts_arm: assert property (
		seek_cmd |=> seek_go_o == das_onehot($past(tgt)))
		else $error("seek did not start the targeted arm");
	chk_auto_switch: assert property (
		auto_seek ##0 code != das_pkg::CODE_HOLD_RW
		|=> s_r.seek_arm != $past(tgt) && rw_arm_o != $past(tgt))
		else $error("routing switches did not move to the other arm");
	chk_first_seek_arm0: assert property (
		auto_seek ##0 !s_r.seek_seen |=> seek_go_o == 2'b01)
		else $error("first seek after reset not on arm 0");
	chk_hold_code: assert property (
		auto_seek ##0 code == das_pkg::CODE_HOLD_RW
		|=> rw_arm_o == $past(tgt))
		else $error("code 4 seek switched read/write routing");
	chk_inquiry_arm: assert property (
		ce_i && cmd_wr && op == das_pkg::OP_INQUIRY && !blocked && !sel_mode
		|=> s_r.seek_arm == $past(s_r.rw_arm) && $stable(rw_arm_o))
		else $error("inquiry did not keep the last read/write arm");
	chk_no_switch_adv: assert property (
		ce_i && cmd_wr && (op == das_pkg::OP_ADVANCE || op == das_pkg::OP_JUMP)
		|=> $stable(rw_arm_o) && $stable(s_r.seek_arm))
		else $error("advance or jump switched routing");
	chk_sel_ignored: assert property (
		ce_i && !sel_mode |=> $stable(s_r.sel_arm))
		else $error("arm pulse acted outside select mode");
	chk_interlock_set: assert property (
		ce_i && cmd_wr && valid_op && sel_mode && s_r.sel_arm &&
		!s_r.arm0_used |=> interlock_o && seek_go_o == 2'b00)
		else $error("arm 1 before arm 0 did not interlock");
	chk_interlock_hold: assert property (
		interlock_o && !s_r.ckr_pend |=> interlock_o)
		else $error("interlock released without check reset");
	chk_bus_answer: assert property (
		ce_i && req && avs_waitrequest_o && $past(avs_waitrequest_o)
		|=> !avs_waitrequest_o)
		else $error("slave did not answer in one cycle");

	// check reset seen, then program start edge
	sequence release_steps;
		ce_i && s_r.ckr_pend && pst_p;
	endsequence

	chk_release_clears: assert property (
		release_steps |=> !interlock_o && s_r.arm0_used)
		else $error("interlock not released after program start");
	chk_rw_auto_arm: assert property (
		ce_i && cmd_wr && op == das_pkg::OP_RW && !blocked && !sel_mode
		|=> rw_go_o == das_onehot($past(s_r.rw_arm)))
		else $error("read/write not on the routed arm");
	chk_rw_sel_arm: assert property (
		ce_i && cmd_wr && op == das_pkg::OP_RW && !blocked && sel_mode
		|=> rw_go_o == das_onehot($past(s_r.sel_arm)))
		else $error("read/write not on the selected arm");
	chk_refused_quiet: assert property (
		ce_i && cmd_wr && valid_op && blocked
		|=> seek_go_o == 2'b00 && rw_go_o == 2'b00)
		else $error("refused command moved an arm");
	chk_sel_pick: assert property (
		ce_i && sel_mode && sel1_p && !sel0_p |=> s_r.sel_arm)
		else $error("arm 1 pulse did not select arm 1");
	chk_mode_default: assert property (
		seek_cmd ##0 !sel_mode |=> s_r.seek_arm != $past(s_r.seek_arm))
		else $error("automatic seek did not alternate arms");
	chk_sel_keeps_arm: assert property (
		seek_cmd ##0 sel_mode
		|=> seek_go_o == das_onehot($past(s_r.sel_arm)) &&
		$stable(s_r.seek_arm))
		else $error("select mode seek left the selected arm");
endmodule
`default_nettype wire

// ===== das_arm_model.sv
// partner model: two access arms counting seek and read/write starts
`timescale 1ns/1ps
`default_nettype none
module das_arm_model (
	input wire logic clk_i, // clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic [1:0] seek_go_i, // seek start per arm
	input wire logic [1:0] rw_go_i, // read/write start per arm
	output logic [15:0] seek_cnt_o, // seeks, arm 1 in high byte
	output logic [15:0] rw_cnt_o // read/writes, arm 1 in high byte
);
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			seek_cnt_o <= 16'h0000;
			rw_cnt_o <= 16'h0000;
		end else begin
			seek_cnt_o <= seek_cnt_o + {7'h00, seek_go_i[1], 7'h00, seek_go_i[0]};
			rw_cnt_o <= rw_cnt_o + {7'h00, rw_go_i[1], 7'h00, rw_go_i[0]};
		end
	end
endmodule
`default_nettype wire

// ===== tb_das_seq.sv
// self-checking testbench for the dual access arm sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_das_seq;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wrq = 1'b0;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] rdat;
	logic wait_r;
	logic sel_en = 1'b0;
	logic [3:0] imp = 4'h0;
	logic [1:0] seek_go;
	logic [1:0] rw_go;
	logic ilk;
	logic rwa;
	logic [19:0] a0o;
	logic [19:0] a1o;
	logic [15:0] seek_cnt;
	logic [15:0] rw_cnt;
	int miscompares = 0;
	int checked = 0;

	always #10 clk_i = ~clk_i;

	das_seq dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wrq),
		.avs_writedata_i(wd), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wait_r), .sel_en_i(sel_en), .sel0_i(imp[0]),
		.sel1_i(imp[1]), .check_reset_i(imp[2]), .prog_start_i(imp[3]),
		.seek_go_o(seek_go), .rw_go_o(rw_go), .rw_arm_o(rwa),
		.interlock_o(ilk), .arm0_addr_o(a0o), .arm1_addr_o(a1o));

	das_arm_model arm_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.seek_go_i(seek_go), .rw_go_i(rw_go), .seek_cnt_o(seek_cnt),
		.rw_cnt_o(rw_cnt));

	task close_out;
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// hold request until waitrequest is sampled low, then release
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		begin
			adr <= a;
			wrq <= w;
			rd <= !w;
			wd <= d;
			do begin
				@(posedge clk_i);
			end while (wait_r !== 1'b0);
			q = rdat;
			rd <= 1'b0;
			wrq <= 1'b0;
			@(posedge clk_i);
		end
	endtask

	task wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		begin
			bus(1'b0, a, 32'h0000_0000, q);
			cmp(q & m, e);
		end
	endtask

	task cnt(input logic [31:0] e);
		@(posedge clk_i);
		cmp({seek_cnt, rw_cnt}, e);
	endtask

	task seek(input logic [19:0] a);
		wr(das_pkg::OFS_SEEK_BUF, {12'h000, a});
		wr(das_pkg::OFS_CMD, {29'h0000_0000, das_pkg::OP_SEEK});
	endtask

	task op(input logic [2:0] o);
		wr(das_pkg::OFS_CMD, {29'h0000_0000, o});
	endtask

	// pins pass a synchroniser, so hold each impulse a few edges
	task pulse(input int k);
		imp[k] <= 1'b1;
		repeat (3) @(posedge clk_i);
		imp[k] <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask

	task reset_dut;
		rst_n_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask

	initial begin
		repeat (5000) @(posedge clk_i);
		miscompares++;
		close_out;
	end

	initial begin
		reset_dut;
		chk(das_pkg::OFS_STATUS, 32'h0000_003f, 32'h0000_0000);
		chk(5'h14, 32'hffff_ffff, 32'h0000_0000);
		seek(20'h1_2345);
		cnt(32'h0001_0000);
		chk(das_pkg::OFS_ARM0, 32'h000f_ffff, 32'h0001_2345);
		cmp({12'h000, a0o}, 32'h0001_2345);
		chk(das_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0003);
		cmp({31'h0000_0000, rwa}, 32'h0000_0001);
		seek(20'h5_4321);
		cnt(32'h0101_0000);
		chk(das_pkg::OFS_ARM1, 32'h000f_ffff, 32'h0005_4321);
		cmp({12'h000, a1o}, 32'h0005_4321);
		chk(das_pkg::OFS_ARM0, 32'h000f_ffff, 32'h0001_2345);
		chk(das_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0000);
		op(das_pkg::OP_RW);
		cnt(32'h0101_0001);
		// seek holding read/write on the arm being sought
		wr(das_pkg::OFS_SEEK_BUF, 32'h0000_0777);
		wr(das_pkg::OFS_CMD, {24'h00_0000, das_pkg::CODE_HOLD_RW, 1'b0,
			das_pkg::OP_SEEK});
		chk(das_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0001);
		op(das_pkg::OP_RW);
		cnt(32'h0102_0002);
		seek(20'h0_0500);
		chk(das_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0000);
		cnt(32'h0202_0002);
		op(das_pkg::OP_ADVANCE);
		chk(das_pkg::OFS_ARM0, 32'h000f_ffff, 32'h0000_0778);
		wr(das_pkg::OFS_CMD, {20'h0_0000, 4'h9, 5'h00, das_pkg::OP_JUMP});
		chk(das_pkg::OFS_ARM0, 32'h000f_ffff, 32'h0000_0779);
		chk(das_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0000);
		wr(das_pkg::OFS_SEEK_BUF, 32'h0000_0111);
		op(das_pkg::OP_INQUIRY);
		cnt(32'h0203_0002);
		chk(das_pkg::OFS_ARM0, 32'h000f_ffff, 32'h0000_0111);
		chk(das_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0000);
		// select mode from a fresh power-on state
		reset_dut;
		sel_en <= 1'b1;
		repeat (4) @(posedge clk_i);
		pulse(1);
		seek(20'h0_0222);
		chk(das_pkg::OFS_STATUS, 32'h0000_0018, 32'h0000_0018);
		cmp({31'h0000_0000, ilk}, 32'h0000_0001);
		cnt(32'h0000_0000);
		pulse(2);
		pulse(3);
		cmp({31'h0000_0000, ilk}, 32'h0000_0000);
		seek(20'h0_0222);
		seek(20'h0_0333);
		op(das_pkg::OP_RW);
		cnt(32'h0200_0100);
		chk(das_pkg::OFS_ARM1, 32'h000f_ffff, 32'h0000_0333);
		chk(das_pkg::OFS_STATUS, 32'h0000_000e, 32'h0000_000e);
		cmp({31'h0000_0000, rwa}, 32'h0000_0001);
		pulse(0);
		seek(20'h0_0444);
		cnt(32'h0201_0100);
		sel_en <= 1'b0;
		repeat (4) @(posedge clk_i);
		pulse(1);
		chk(das_pkg::OFS_STATUS, 32'h0000_000c, 32'h0000_0000);
		close_out;
	end
endmodule
`default_nettype wire
